// ===== src/codec_serial_defines.svh
// Register indices, field positions, reset values and frame constants for the codec serial block
`ifndef CODEC_SERIAL_DEFINES_SVH
`define CODEC_SERIAL_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_CTRL1 10'h240
`define IDX_CTRL2 10'h242
`define IDX_BITCLK 10'h244
`define IDX_STATUS 10'h246
`define IDX_TX_SLOT 10'h248
`define IDX_RX_SLOT 10'h24C
`define IDX_RXBUF0 10'h250
`define IDX_RXBUF3 10'h256
`define IDX_TXBUF0 10'h258
`define IDX_TXBUF3 10'h25E

// Control word 1 bit positions
`define C1_ENABLE 15
`define C1_IDLE_HALT 13
`define C1_LOOP 11
`define C1_CLK_DIR 10
`define C1_UNDERFLOW_REPEAT_SEL 7
`define C1_UNUSED_SLOT_OUTPUT_MODE 6
`define C1_WR_MASK 16'hACC3

// Control word 2 field positions
`define C2_BLEN_LSB 10
`define C2_FLEN_LSB 4
`define C2_WS_LSB 0
`define C2_WR_MASK 16'h0CFF

// Status word bit positions
`define ST_SLOT_LSB 8
`define ST_ROV 3
`define ST_RX_FULL_FLAG 2
`define ST_TX_UNDERFLOW_FLAG 1
`define ST_TX_BUFFER_EMPTY_FLAG 0

// Reset value of every register
`define REG_RESET 16'h0000

// Frame constants
`define WORD_BITS 5'h10
`define AC_SLOT_BITS 5'h14
`define AC16_LAST_SLOT 4'hC
`define AC20_LAST_SLOT 4'hF
`define BIT_CNT_IDLE 5'h1F

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== src/codec_serial_pkg.sv
// Types shared by the codec serial block
package codec_serial_pkg;

	// Frame sync format
	typedef enum logic [1:0] {
		MODE_MULTI = 2'b00,
		MODE_I2S = 2'b01,
		MODE_AC16 = 2'b10,
		MODE_AC20 = 2'b11
	} frame_mode_t;

	// Decoded configuration
	typedef struct packed {
		logic enable;
		logic idle_halt_sel;
		logic internal_loopback_sel;
		logic bit_clock_direction;
		logic underflow_repeat_sel;
		logic unused_slot_output_mode;
		frame_mode_t frame_sync_format_sel;
		logic [1:0] buffer_length_sel;
		logic [3:0] frame_length_sel;
		logic [3:0] word_size_sel;
	} cfg_t;

endpackage

// ===== src/codec_serial_buffer_status.sv
// Codec serial link buffers, status flags, frame formats and AXI4-Lite registers
// Operation
// - Transmit-empty flag sets when transmit words copy into transmit shadows.
// - Any CPU write to a transmit buffer word clears transmit-empty.
// - Read-only transmit-underflow sets at transfer if an in-use word underflowed.
// - Writing the underflowed transmit word clears its underflow.
// - Underflow, overflow and receive-full consider only buffer words in use under buffer length.
// - Receive-full sets on new data, clears once all in-use words read.
// - Receive-overflow sets when unread word is refilled; reading it clears.
// - On overflow the unread receive word is overwritten with new data.
// - Four-bit slot status mirrors the frame sync generator slot counter once the link starts, zero before.
// - Disabled transmit slot: output low if mode bit 0, tri-state if 1.
// - Loopback routes serial output to input, ignoring the input pin.
// - Underflow sends zeros, or resends last written data when repeat set.
// - Interrupt at each shadow transfer when buffer length is reached.
// - Transfer moves transmit words to shadows and receive shadows to words.
// - Asleep with external bit clock: keep running, raise wake on transfer.
// - CPU idle: run when idle-halt is 0, stop when it is 1.
// - Format 10 selects 16-bit AC-Link, 11 selects 20-bit AC-Link.
// - AC-Link frame is 256 bits: one 16-bit slot, twelve 20-bit slots.
// - 16-bit AC-Link: receive truncates to 16, transmit low 4 bits zero.
// - 20-bit AC-Link: frame sync high 16 bit clocks, low 240.
// - 20-bit AC-Link: frame is sixteen 16-bit slots, no 20-bit alignment.
// - Format 01 is I2S: 50 percent frame sync, each edge starts a frame.
// - Buffer counter wraps to zero with transfer when it equals buffer length.
// - Enabled transmit slot loads shadow word and advances the buffer counter.
`timescale 1ns/1ps
`include "codec_serial_defines.svh"

module codec_serial_buffer_status #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// AXI4-Lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// CPU power state
	input wire logic cpu_idle,
	input wire logic cpu_sleep,
	// Serial link
	input wire logic serial_bit_clock_in,
	output logic serial_bit_clock_out,
	output logic serial_bit_clock_oe,
	output logic frame_sync_signal,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_out_oe,
	// Events
	output logic buffer_irq,
	output logic wake_req
);

	////////////////////////////////////////////////////////////////////////////////
	// Registers and configuration

	logic [15:0] ctrl1_q, ctrl2_q, bitclk_div_q, tx_slot_enable_q, rx_slot_enable_q;
	logic [15:0] tx_buffer_word_q [4];
	logic [15:0] rx_buffer_word_q [4];
	logic [15:0] tx_shadow_q [4];
	logic [15:0] rx_shadow_q [4];
	logic [15:0] tx_shadow_d [4];
	logic [15:0] rx_shadow_d [4];
	codec_serial_pkg::cfg_t cfg;

	// Decode control words into fields
	always_comb begin
		cfg.enable = ctrl1_q[`C1_ENABLE];
		cfg.idle_halt_sel = ctrl1_q[`C1_IDLE_HALT];
		cfg.internal_loopback_sel = ctrl1_q[`C1_LOOP];
		cfg.bit_clock_direction = ctrl1_q[`C1_CLK_DIR];
		cfg.underflow_repeat_sel = ctrl1_q[`C1_UNDERFLOW_REPEAT_SEL];
		cfg.unused_slot_output_mode = ctrl1_q[`C1_UNUSED_SLOT_OUTPUT_MODE];
		cfg.frame_sync_format_sel = codec_serial_pkg::frame_mode_t'(ctrl1_q[1:0]);
		cfg.buffer_length_sel = ctrl2_q[`C2_BLEN_LSB +: 2];
		cfg.frame_length_sel = ctrl2_q[`C2_FLEN_LSB +: 4];
		cfg.word_size_sel = ctrl2_q[`C2_WS_LSB +: 4];
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q, rdata_q;
	logic [3:0] w_strb_q;
	logic [1:0] bresp_q, rresp_q;
	logic wr_do, rd_take, wr_hit, rd_hit;
	logic [9:0] wr_idx, rd_idx;
	logic [3:0] tx_wr_strobe, rx_rd_strobe;
	logic [15:0] wr_val;

	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready = !w_hold_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign wr_do = aw_hold_q && w_hold_q && !bvalid_q;
	assign rd_take = s_axi_arvalid && !rvalid_q;
	assign wr_idx = 10'(aw_addr_q >> 2);
	assign rd_idx = 10'(s_axi_araddr >> 2);
	assign wr_val = {w_strb_q[1] ? w_data_q[15:8] : 8'h00, w_strb_q[0] ? w_data_q[7:0] : 8'h00};

	// Address decode; buffer words sit on even indices
	always_comb begin
		wr_hit = 1'b1;
		case (wr_idx)
			`IDX_CTRL1, `IDX_CTRL2, `IDX_BITCLK, `IDX_STATUS, `IDX_TX_SLOT, `IDX_RX_SLOT: begin
				wr_hit = 1'b1;
			end
			default: begin
				wr_hit = !wr_idx[0] && wr_idx >= `IDX_RXBUF0 && wr_idx <= `IDX_TXBUF3;
			end
		endcase
		tx_wr_strobe = 4'h0;
		if (wr_do && !wr_idx[0] && wr_idx >= `IDX_TXBUF0 && wr_idx <= `IDX_TXBUF3) begin
			tx_wr_strobe = 4'h1 << wr_idx[2:1];
		end
		rx_rd_strobe = 4'h0;
		if (rd_take && !rd_idx[0] && rd_idx >= `IDX_RXBUF0 && rd_idx <= `IDX_RXBUF3) begin
			rx_rd_strobe = 4'h1 << rd_idx[2:1];
		end
	end

	// Write channel capture and response
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_do) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Software-written registers; status and receive words are read-only
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ctrl1_q <= `REG_RESET;
			ctrl2_q <= `REG_RESET;
			bitclk_div_q <= `REG_RESET;
			tx_slot_enable_q <= `REG_RESET;
			rx_slot_enable_q <= `REG_RESET;
			for (int i = 0; i < 4; i++) begin
				tx_buffer_word_q[i] <= `REG_RESET;
			end
		end else if (wr_do) begin
			case (wr_idx)
				`IDX_CTRL1: ctrl1_q <= wr_val & `C1_WR_MASK;
				`IDX_CTRL2: ctrl2_q <= wr_val & `C2_WR_MASK;
				`IDX_BITCLK: bitclk_div_q <= {4'h0, wr_val[11:0]};
				`IDX_TX_SLOT: tx_slot_enable_q <= wr_val;
				`IDX_RX_SLOT: rx_slot_enable_q <= wr_val;
				default: begin
					for (int i = 0; i < 4; i++) begin
						if (tx_wr_strobe[i]) begin
							tx_buffer_word_q[i] <= wr_val;
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link clock: external sampled, or internal divider

	logic clk_s1_q, clk_s2_q, clk_s3_q, din_s1_q, din_s2_q;
	logic int_clk_q, run, rise_tick, fall_tick, div_hit;
	logic [11:0] div_cnt_q;

	// Halt in idle when asked, and in sleep unless the bit clock comes from outside
	assign run = cfg.enable && !(cpu_idle && cfg.idle_halt_sel)
		&& !(cpu_sleep && !cfg.bit_clock_direction);
	assign div_hit = run && bitclk_div_q[11:0] != 12'h000 && div_cnt_q == bitclk_div_q[11:0];
	assign rise_tick = run && (cfg.bit_clock_direction ? (clk_s2_q && !clk_s3_q)
		: (div_hit && !int_clk_q));
	assign fall_tick = run && (cfg.bit_clock_direction ? (!clk_s2_q && clk_s3_q)
		: (div_hit && int_clk_q));
	assign serial_bit_clock_out = int_clk_q;
	assign serial_bit_clock_oe = cfg.enable && !cfg.bit_clock_direction;

	// Pin synchronisers and edge history
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_s3_q <= 1'b0;
			din_s1_q <= 1'b0;
			din_s2_q <= 1'b0;
		end else begin
			clk_s1_q <= serial_bit_clock_in;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
			din_s1_q <= serial_data_in;
			din_s2_q <= din_s1_q;
		end
	end

	// Internal divider toggles the bit clock every divisor+1 cycles
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !run || bitclk_div_q[11:0] == 12'h000) begin
			div_cnt_q <= 12'h000;
			int_clk_q <= 1'b0;
		end else if (div_hit) begin
			div_cnt_q <= 12'h000;
			int_clk_q <= !int_clk_q;
		end else begin
			div_cnt_q <= div_cnt_q + 12'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Frame sync generator and slot timing

	logic [4:0] bit_cnt_q, bit_n, slot_len, data_bits;
	logic [3:0] slot_q, slot_n, last_slot;
	logic [1:0] addr_q, addr_d;
	logic [15:0] tx_shift_q, rx_shift_q, rx_just, load_word;
	logic started_q, end_slot, slot_used, xfer, load_en, rx_bit, fs_q, sdo_q, sdo_oe_q;
	logic [3:0] use_mask;

	// Slot geometry per format
	always_comb begin
		case (cfg.frame_sync_format_sel)
			codec_serial_pkg::MODE_AC16: begin
				slot_len = (slot_q == 4'h0) ? `WORD_BITS : `AC_SLOT_BITS;
				last_slot = `AC16_LAST_SLOT;
				data_bits = `WORD_BITS;
			end
			codec_serial_pkg::MODE_AC20: begin
				slot_len = `WORD_BITS;
				last_slot = `AC20_LAST_SLOT;
				data_bits = `WORD_BITS;
			end
			default: begin
				slot_len = {1'b0, cfg.word_size_sel} + 5'h01;
				last_slot = cfg.frame_length_sel;
				data_bits = {1'b0, cfg.word_size_sel} + 5'h01;
			end
		endcase
		end_slot = bit_cnt_q >= slot_len - 5'h01;
		bit_n = end_slot ? 5'h00 : bit_cnt_q + 5'h01;
		slot_n = !end_slot ? slot_q : (slot_q >= last_slot) ? 4'h0 : slot_q + 4'h1;
		rx_just = rx_shift_q << (5'h10 - data_bits);
		for (int i = 0; i < 4; i++) begin
			use_mask[i] = 2'(i) <= cfg.buffer_length_sel;
		end
	end

	// Which transmit words software has written since the last transfer
	logic [3:0] tx_written_q;

	function automatic logic tx_unwritten(input int idx);
		return !tx_written_q[idx[1:0]];
	endfunction

	// Buffer counter, shadow capture and transfer
	always_comb begin
		slot_used = started_q && (tx_slot_enable_q[slot_q] || rx_slot_enable_q[slot_q]);
		rx_shadow_d = rx_shadow_q;
		addr_d = addr_q;
		xfer = 1'b0;
		if (rise_tick && end_slot && slot_used) begin
			if (rx_slot_enable_q[slot_q]) begin
				rx_shadow_d[addr_q] = rx_just;
			end
			if (addr_q == cfg.buffer_length_sel) begin
				xfer = 1'b1;
				addr_d = 2'h0;
			end else begin
				addr_d = addr_q + 2'h1;
			end
		end
		for (int i = 0; i < 4; i++) begin
			tx_shadow_d[i] = tx_shadow_q[i];
			if (xfer) begin
				// Unwritten word sends silence or repeats its last value
				tx_shadow_d[i] = (tx_unwritten(i) && !cfg.underflow_repeat_sel) ? 16'h0000
					: tx_buffer_word_q[i];
			end
		end
		load_en = rise_tick && end_slot && tx_slot_enable_q[slot_n];
		load_word = tx_shadow_d[addr_d];
	end

	assign rx_bit = cfg.internal_loopback_sel ? sdo_q : din_s2_q;
	assign frame_sync_signal = fs_q;
	assign serial_data_out = sdo_q;
	assign serial_data_out_oe = sdo_oe_q;

	// Counters, shifters, frame sync and data pin
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !cfg.enable) begin
			bit_cnt_q <= `BIT_CNT_IDLE;
			slot_q <= `AC20_LAST_SLOT;
			started_q <= 1'b0;
			addr_q <= 2'h0;
			tx_shift_q <= 16'h0000;
			rx_shift_q <= 16'h0000;
			fs_q <= 1'b0;
			sdo_q <= 1'b0;
			sdo_oe_q <= 1'b0;
		end else begin
			if (fall_tick && bit_cnt_q < data_bits) begin
				rx_shift_q <= {rx_shift_q[14:0], rx_bit};
			end
			if (rise_tick) begin
				started_q <= 1'b1;
				bit_cnt_q <= bit_n;
				slot_q <= slot_n;
				addr_q <= addr_d;
				if (load_en) begin
					tx_shift_q <= {load_word[14:0], 1'b0};
				end else begin
					tx_shift_q <= {tx_shift_q[14:0], 1'b0};
				end
				// Bits past the sixteenth of a long slot go out as zero
				if (!tx_slot_enable_q[slot_n] || bit_n >= `WORD_BITS) begin
					sdo_q <= 1'b0;
				end else begin
					sdo_q <= load_en ? load_word[15] : tx_shift_q[15];
				end
				sdo_oe_q <= tx_slot_enable_q[slot_n] || !cfg.unused_slot_output_mode;
				case (cfg.frame_sync_format_sel)
					codec_serial_pkg::MODE_I2S: begin
						if (end_slot && slot_n == 4'h0) begin
							fs_q <= !fs_q;
						end
					end
					codec_serial_pkg::MODE_AC16, codec_serial_pkg::MODE_AC20: begin
						fs_q <= slot_n == 4'h0;
					end
					default: begin
						fs_q <= slot_n == 4'h0 && bit_n == 5'h00;
					end
				endcase
			end
		end
	end

	// Shadow and receive word storage
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			for (int i = 0; i < 4; i++) begin
				tx_shadow_q[i] <= `REG_RESET;
				rx_shadow_q[i] <= `REG_RESET;
				rx_buffer_word_q[i] <= `REG_RESET;
			end
		end else begin
			tx_shadow_q <= tx_shadow_d;
			rx_shadow_q <= rx_shadow_d;
			if (xfer) begin
				rx_buffer_word_q <= rx_shadow_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status flags and events

	logic tx_empty_q, rx_full_q, irq_q, wake_q;
	logic [3:0] tx_unf_q, rx_read_q, rx_ovf_q;

	// Hardware sets win over clears in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			tx_empty_q <= 1'b0;
			rx_full_q <= 1'b0;
			tx_written_q <= 4'h0;
			tx_unf_q <= 4'h0;
			// Nothing unread after reset, so the first transfer is no overflow
			rx_read_q <= 4'hF;
			rx_ovf_q <= 4'h0;
		end else begin
			if (xfer) begin
				tx_empty_q <= 1'b1;
			end else if (|tx_wr_strobe) begin
				tx_empty_q <= 1'b0;
			end
			tx_written_q <= xfer ? tx_wr_strobe : (tx_written_q | tx_wr_strobe);
			tx_unf_q <= xfer ? (tx_unf_q & ~tx_wr_strobe) | (~tx_written_q & use_mask)
				: tx_unf_q & ~tx_wr_strobe;
			rx_read_q <= xfer ? 4'h0 : (rx_read_q | rx_rd_strobe);
			rx_ovf_q <= xfer ? (rx_ovf_q & ~rx_rd_strobe) | (~rx_read_q & use_mask)
				: rx_ovf_q & ~rx_rd_strobe;
			if (xfer) begin
				rx_full_q <= 1'b1;
			end else if (&((rx_read_q | rx_rd_strobe) | ~use_mask)) begin
				rx_full_q <= 1'b0;
			end
		end
	end

	// Transfer interrupt and sleep wake request
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			irq_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			irq_q <= xfer;
			if (xfer && cpu_sleep) begin
				wake_q <= 1'b1;
			end else if (!cpu_sleep) begin
				wake_q <= 1'b0;
			end
		end
	end
	assign buffer_irq = irq_q;
	assign wake_req = wake_q;

	// Read data and response
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `RESP_OKAY;
		end else if (rd_take) begin
			rvalid_q <= 1'b1;
			rresp_q <= `RESP_OKAY;
			rdata_q <= 32'h0000_0000;
			case (rd_idx)
				`IDX_CTRL1: rdata_q[15:0] <= ctrl1_q;
				`IDX_CTRL2: rdata_q[15:0] <= ctrl2_q;
				`IDX_BITCLK: rdata_q[15:0] <= bitclk_div_q;
				`IDX_STATUS: begin
					// Idle counter parks at the last slot; report zero until the link starts
					rdata_q[`ST_SLOT_LSB +: 4] <= started_q ? slot_q : 4'h0;
					rdata_q[`ST_ROV] <= |(rx_ovf_q & use_mask);
					rdata_q[`ST_RX_FULL_FLAG] <= rx_full_q;
					rdata_q[`ST_TX_UNDERFLOW_FLAG] <= |(tx_unf_q & use_mask);
					rdata_q[`ST_TX_BUFFER_EMPTY_FLAG] <= tx_empty_q;
				end
				`IDX_TX_SLOT: rdata_q[15:0] <= tx_slot_enable_q;
				`IDX_RX_SLOT: rdata_q[15:0] <= rx_slot_enable_q;
				default: begin
					if (|rx_rd_strobe) begin
						rdata_q[15:0] <= rx_buffer_word_q[rd_idx[2:1]];
					end else if (!rd_idx[0] && rd_idx >= `IDX_TXBUF0 && rd_idx <= `IDX_TXBUF3) begin
						rdata_q[15:0] <= tx_buffer_word_q[rd_idx[2:1]];
					end else begin
						rresp_q <= `RESP_SLVERR;
					end
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions and covers

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	chk_tx_buffer_empty_flag_set: assert property (xfer |=> tx_empty_q)
		else $error("transmit empty not set after transfer");
	chk_tx_buffer_empty_flag_clr: assert property ((|tx_wr_strobe && !xfer) |=> !tx_empty_q)
		else $error("transmit empty not cleared by buffer write");
	chk_unf_zero: assert property (xfer && !tx_written_q[0] && !cfg.underflow_repeat_sel
		|=> tx_shadow_q[0] == 16'h0000)
		else $error("underflowed word not silenced");
	chk_ovf_set: assert property (xfer && use_mask[0] && !rx_read_q[0]
		|=> rx_ovf_q[0])
		else $error("receive overflow missed");
	chk_rx_full_flag_set: assert property (xfer |=> rx_full_q)
		else $error("receive full not set after transfer");
	chk_irq_pulse: assert property (xfer |=> buffer_irq ##1 (!buffer_irq || $past(xfer)))
		else $error("transfer interrupt not a pulse on transfer");
	chk_addr_wrap: assert property (xfer |=> addr_q == 2'h0)
		else $error("buffer counter did not wrap on transfer");
	chk_sdo_unused: assert property (rise_tick && end_slot && !tx_slot_enable_q[slot_n]
		|=> !serial_data_out && (serial_data_out_oe == !cfg.unused_slot_output_mode))
		else $error("unused slot output wrong");
	chk_ac_sync: assert property (cfg.frame_sync_format_sel == codec_serial_pkg::MODE_AC20
		&& started_q && $stable(cfg) |-> frame_sync_signal == (slot_q == 4'h0))
		else $error("AC-Link frame sync misplaced");
	chk_idle_halt: assert property (cpu_idle && cfg.idle_halt_sel |-> !rise_tick && !fall_tick)
		else $error("link ran during idle halt");

	cov_transfer: cover property (xfer ##[1:50] xfer);
	cov_overflow: cover property (rx_ovf_q[0] ##1 !rx_ovf_q[0]);
	cov_underflow: cover property (xfer && !tx_written_q[0]);
	cov_loopback: cover property (cfg.internal_loopback_sel && xfer);

endmodule

// ===== dv/codec_model.sv
// Behavioural codec model on the far side of the serial link
`timescale 1ns/1ps
module codec_model (
	// Link
	input wire logic bit_clk,
	input wire logic data_from_dev,
	input wire logic data_from_dev_oe,
	output logic data_to_dev
);
	logic level_q = 1'b0;
	assign data_to_dev = level_q;
	// Echo inverted data; a released line toggles so no stale level shows
	always @(posedge bit_clk) begin
		level_q <= data_from_dev_oe ? ~data_from_dev : ~level_q;
	end
endmodule

// ===== dv/tb.sv
// Self-checking bench for the codec serial buffer and status block
`timescale 1ns/1ps
`include "codec_serial_defines.svh"
module tb;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic [1:0] bresp, rresp, rr, br, div_q = 2'h0;
	logic bclk_oe;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, cpu_idle = 1'b0, cpu_sleep = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, bclk = 1'b0, sdi, sdo, sdo_oe;
	logic frame_sync_signal, buffer_irq, wake_req;
	int err_total = 0;
	int check_count = 0;
	int n;
	always #12.5 ref_clk = ~ref_clk;
	// External bit clock, 200 ns period
	always @(posedge ref_clk) begin
		div_q <= div_q + 2'h1;
		if (div_q == 2'h3) bclk <= ~bclk;
	end
	codec_serial_buffer_status codec_serial_buffer_status_inst (.ref_clk(ref_clk),
		.reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .serial_bit_clock_in(bclk),
		.serial_bit_clock_out(), .serial_bit_clock_oe(bclk_oe),
		.frame_sync_signal(frame_sync_signal),
		.serial_data_in(sdi), .serial_data_out(sdo), .serial_data_out_oe(sdo_oe),
		.buffer_irq(buffer_irq), .wake_req(wake_req));
	codec_model codec_model_inst (.bit_clk(bclk), .data_from_dev(sdo),
		.data_from_dev_oe(sdo_oe), .data_to_dev(sdi));
	////////////////////////////////////////////////////////////////
	// Verdict and comparisons
	task automatic print_verdict;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic bad(input string m);
		err_total++;
		$display("mismatch at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) bad($sformatf("got %h want %h", got, exp));
	endtask
	task automatic rng(input int got, input int exp);
		check_count++;
		if (got > exp + 3 || got + 3 < exp) bad($sformatf("width %0d want %0d", got, exp));
	endtask
	task automatic hang;
		bad("timeout");
		print_verdict();
	endtask
	////////////////////////////////////////////////////////////////
	// Bus cycles and waits
	task automatic wr(input logic [9:0] idx, input logic [15:0] d);
		int k;
		k = 0;
		awaddr <= {idx, 2'b00};
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			k++;
			if (k > 50) hang();
		end while (!bvalid);
		br = bresp;
	endtask
	task automatic rd(input logic [9:0] idx);
		int k;
		k = 0;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arready) arvalid <= 1'b0;
			k++;
			if (k > 50) hang();
		end while (!rvalid);
		rv = rdata;
		rr = rresp;
	endtask
	task automatic wait_irq(input int cnt);
		int k;
		repeat (cnt) begin
			k = 0;
			do begin
				@(posedge ref_clk);
				k++;
				if (k > 3000) hang();
			end while (!buffer_irq);
		end
	endtask
	// Measure frame sync high and low widths in clock cycles
	task automatic fsync(input logic [1:0] fmt, input int hi, input int lo);
		int h, l, k;
		wr(`IDX_CTRL1, 16'h0000);
		wr(`IDX_CTRL1, {14'h2100, fmt});
		k = 0;
		while (frame_sync_signal !== 1'b0 && k < 5000) begin @(posedge ref_clk); k++; end
		while (frame_sync_signal !== 1'b1 && k < 5000) begin @(posedge ref_clk); k++; end
		h = 0;
		while (frame_sync_signal === 1'b1 && h < 5000) begin @(posedge ref_clk); h++; end
		l = 0;
		while (frame_sync_signal === 1'b0 && l < 5000) begin @(posedge ref_clk); l++; end
		if (k >= 5000) hang();
		rng(h, hi);
		rng(l, lo);
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		rd(10'h001);
		chk({14'h0, rr}, `RESP_SLVERR);
		wr(10'h001, 16'h0000);
		chk({14'h0, br}, `RESP_SLVERR);
		rd(`IDX_STATUS);
		chk(rv[15:0], `REG_RESET);
		wr(`IDX_CTRL2, 16'hFFFF);
		rd(`IDX_CTRL2);
		chk(rv[15:0], `C2_WR_MASK);
		wr(`IDX_CTRL2, 16'h041F);
		wr(`IDX_TX_SLOT, 16'h0003);
		wr(`IDX_RX_SLOT, 16'h0003);
		wr(`IDX_TXBUF0, 16'h1111);
		wr(`IDX_TXBUF0 + 10'h2, 16'h2222);
		wr(`IDX_CTRL1, 16'h8C00);
		wait_irq(1);
		rd(`IDX_STATUS);
		chk({13'h0, rv[2:0]}, 16'h0005);
		wr(`IDX_TXBUF0, 16'hA5A5);
		rd(`IDX_RXBUF0);
		rd(`IDX_RXBUF0 + 10'h2);
		rd(`IDX_STATUS);
		chk({13'h0, rv[2:0]}, 16'h0000);
		wait_irq(1);
		rd(`IDX_STATUS);
		chk({12'h0, rv[3:0]}, 16'h0007);
		wr(`IDX_TXBUF0 + 10'h2, 16'h5A5A);
		rd(`IDX_STATUS);
		chk({12'h0, rv[3:0]}, 16'h0004);
		wait_irq(1);
		rd(`IDX_RXBUF0);
		rd(`IDX_STATUS);
		chk({15'h0, rv[3]}, 16'h0001);
		rd(`IDX_RXBUF0 + 10'h2);
		rd(`IDX_STATUS);
		chk({15'h0, rv[3]}, 16'h0000);
		wr(`IDX_CTRL1, 16'h0000);
		wr(`IDX_CTRL2, 16'h001F);
		wr(`IDX_CTRL1, 16'h8C00);
		repeat (4) begin
			wait_irq(1);
			wr(`IDX_TXBUF0, 16'hC3A5);
		end
		wait_irq(1);
		rd(`IDX_STATUS);
		chk({15'h0, rv[1]}, 16'h0000);
		rd(`IDX_RXBUF0);
		chk(rv[15:0], 16'hC3A5);
		wait_irq(3);
		rd(`IDX_RXBUF0);
		chk(rv[15:0], 16'h0000);
		wr(`IDX_CTRL1, 16'h8C80);
		wr(`IDX_TXBUF0, 16'h1234);
		wait_irq(4);
		rd(`IDX_RXBUF0);
		chk(rv[15:0], 16'h1234);
		wr(`IDX_CTRL1, 16'hAC00);
		cpu_idle <= 1'b1;
		n = 0;
		repeat (1500) begin @(posedge ref_clk); if (buffer_irq) n++; end
		chk(n[15:0], 16'h0000);
		cpu_idle <= 1'b0;
		cpu_sleep <= 1'b1;
		wait_irq(1);
		@(posedge ref_clk);
		chk({15'h0, wake_req}, 16'h0001);
		chk({15'h0, bclk_oe}, 16'h0000);
		cpu_sleep <= 1'b0;
		wr(`IDX_CTRL2, 16'h041F);
		fsync(2'b00, 8, 248);
		// Frame sync just rose; early in the second slot the counter shows one
		repeat (140) @(posedge ref_clk);
		rd(`IDX_STATUS);
		chk({12'h0, rv[11:8]}, 16'h0001);
		fsync(2'b01, 256, 256);
		fsync(2'b10, 128, 1920);
		fsync(2'b11, 128, 1920);
		wr(`IDX_CTRL1, 16'h8000);
		chk({15'h0, bclk_oe}, 16'h0001);
		print_verdict();
	end
endmodule
